// ### exec_pkg.sv
// constants, opcodes and decode helpers for the branch, call and move unit
// assumes one t-state per sys_clk cycle and a 16-bit instruction word
package exec_pkg;
  localparam int PHYS_REGS = 44;
  // register map: bank a R0-R3, bank b R4-R11, index pairs from R12
  localparam logic [4:0] BANK_A_HI = 5'h03;
  localparam logic [4:0] BANK_B_LO = 5'h04;
  localparam logic [4:0] BANK_B_HI = 5'h0B;
  localparam logic [4:0] INDEX_BASE = 5'h0C;
  localparam logic [5:0] ALT_A_BASE = 6'h20;
  localparam logic [5:0] ALT_B_BASE = 6'h24;
  localparam logic [1:0] IDX3_SEL = 2'h3;
  // index update modes
  localparam logic [1:0] IDX_POST_DEC = 2'h0;
  localparam logic [1:0] IDX_KEEP = 2'h1;
  localparam logic [1:0] IDX_POST_INC = 2'h2;
  localparam logic [1:0] IDX_PRE_INC = 2'h3;
  // flag positions
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  // field positions
  localparam int SRC_HI = 4;
  localparam int RL_HI = 3;
  localparam int RD_HI = 9;
  localparam int RD_LO = 5;
  localparam int IMM_HI = 7;
  localparam int NI_HI = 11;
  localparam int NI_LO = 4;
  localparam int MASK_HI = 12;
  localparam int MASK_LO = 10;
  localparam int ROT_HI = 7;
  localparam int ROT_LO = 5;
  localparam int SBIT = 8;
  localparam int MODE_HI = 8;
  localparam int MODE_LO = 7;
  localparam int ISEL_HI = 6;
  localparam int ISEL_LO = 5;
  localparam int IRJ_HI = 1;
  // t-state counts
  localparam logic [2:0] T_REL_IMM = 3'h3;
  localparam logic [2:0] T_REL_REG = 3'h4;
  localparam logic [2:0] T_TABLE = 3'h4;
  localparam logic [2:0] T_LONG = 3'h4;
  localparam logic [2:0] T_MEM = 3'h3;
  localparam logic [2:0] T_SHORT = 3'h2;
  localparam logic [2:0] CNT_LAST = 3'h1;
  typedef enum {op_none, op_rel_imm, op_rel_reg, op_table, op_call_abs, op_call_cond,
    op_jump_abs, op_jump_idx, op_jump_cond, op_ld_idx, op_st_idx, op_ld_rel, op_st_rel,
    op_ld_imm, op_st_imm, op_mov_rr, op_or_imm} op_e;
  function automatic logic [15:0] sext8(logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction
  // opcode match table, most specific patterns first
  function automatic op_e decode(logic [15:0] w);
    if (w == 16'hCF00) return op_jump_abs;
    if (w == 16'hCE00) return op_call_abs;
    if ((w & 16'hFFFC) == 16'hCD00) return op_jump_idx;
    if ((w & 16'hFFE0) == 16'hCD80) return op_rel_reg;
    if ((w & 16'hFF00) == 16'hCB00) return op_rel_imm;
    if ((w & 16'hFE00) == 16'hC400) return op_call_cond;
    if ((w & 16'hFE00) == 16'hC600) return op_jump_cond;
    if ((w & 16'hE300) == 16'h8000) return op_table;
    if ((w & 16'hFE00) == 16'hE000) return op_ld_idx;
    if ((w & 16'hFE00) == 16'hE200) return op_st_idx;
    if ((w & 16'hFE00) == 16'hE400) return op_ld_rel;
    if ((w & 16'hFE00) == 16'hE600) return op_st_rel;
    if ((w & 16'hFC00) == 16'hF400) return op_mov_rr;
    if ((w & 16'hF000) == 16'h6000) return op_ld_imm;
    if ((w & 16'hF000) == 16'h7000) return op_st_imm;
    if ((w & 16'hF000) == 16'h5000) return op_or_imm;
    return op_none;
  endfunction
endpackage

// ### banked_regfile.sv
// banked processor register file with main and alternate sets
// assumes bank selects are stable while a write is made
`timescale 1ns/1ps
module banked_regfile #(
  parameter int PHYS = exec_pkg::PHYS_REGS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // bank selection
  input wire logic bank_a_sel,
  input wire logic bank_b_sel,
  // byte read
  input wire logic [4:0] rd_reg,
  output logic [7:0] rd_data,
  output logic [7:0] acc_data,
  // index pair
  input wire logic [1:0] ix_sel,
  output logic [15:0] ix_data,
  input wire logic ix_we,
  input wire logic [15:0] ix_wdata,
  // byte write
  input wire logic wr_en,
  input wire logic [4:0] wr_reg,
  input wire logic [7:0] wr_data
);
  typedef struct packed {
    logic [PHYS-1:0][7:0] mem;
  } rf_s;
  rf_s rf_q;
  rf_s rf_d;
  logic [5:0] ix_lo;

  // map an architectural number onto the active set; idle sets keep their bytes
  function automatic logic [5:0] phys(logic [4:0] r, logic a, logic b);
    if (r <= exec_pkg::BANK_A_HI) begin
      return a ? exec_pkg::ALT_A_BASE + {1'b0, r} : {1'b0, r};
    end else if (r <= exec_pkg::BANK_B_HI) begin
      return b ? exec_pkg::ALT_B_BASE + {1'b0, r - exec_pkg::BANK_B_LO} : {1'b0, r};
    end
    return {1'b0, r};
  endfunction

  // reads: index pairs are never banked, low byte at the even number
  assign ix_lo = {1'b0, exec_pkg::INDEX_BASE + {2'b00, ix_sel, 1'b0}};
  assign rd_data = rf_q.mem[phys(rd_reg, bank_a_sel, bank_b_sel)];
  assign acc_data = rf_q.mem[phys(5'h00, bank_a_sel, bank_b_sel)];
  assign ix_data = {rf_q.mem[ix_lo + 6'h01], rf_q.mem[ix_lo]};

  // byte write after pair write so a data load into an index byte wins
  always_comb begin
    rf_d = rf_q;
    if (ix_we) begin
      rf_d.mem[ix_lo] = ix_wdata[7:0];
      rf_d.mem[ix_lo + 6'h01] = ix_wdata[15:8];
    end
    if (wr_en) begin
      rf_d.mem[phys(wr_reg, bank_a_sel, bank_b_sel)] = wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rf_q <= '0;
    end else begin
      rf_q <= rf_d;
    end
  end
endmodule

// ### branch_call_move_exec.sv
// execution unit for relative, table and long jumps, long calls,
// data moves with index modes and or-immediate
// assumes the fetch unit presents both words and pc of the next instruction
//
// Overview of operation
// - relative jump adds sign-extended byte to pc
// - immediate form three cycles, register form four
// - table jump rotates, masks, sign-extends, adds
// - rotate amount 0-7, zero means none
// - mask clears top m bits and bit 0
// - table source may be any active register
// - conditional call pushes context and loads target in the same cycle
// - tested bit position 0 lsb to 7 msb
// - long targets are full 16-bit addresses
// - unconditional call always pushes context
// - conditional jump loads target, never pushes
// - long jump from operand or index register
// - accumulator-relative address is index plus accumulator
// - immediate-relative address is fourth index plus byte
// - loads: any destination except immediate-relative form
// - stores: any source except immediate-relative form
// - register moves copy one register into another register
// - moves leave all flags unchanged
// - or-immediate updates low register, n and z
// - banks map main or alternate sets
// - index modes: post-dec, keep, post-inc, pre-inc
`timescale 1ns/1ps
module branch_call_move_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] instr_ext,
  input wire logic [15:0] pc_in,
  output logic instr_ready,
  output logic instr_done,
  // processor context
  input wire logic [3:0] flags_in,
  input wire logic global_irq_enable,
  input wire logic bank_a_sel,
  input wire logic bank_b_sel,
  // program counter load
  output logic pc_load,
  output logic [15:0] pc_target,
  // address stack push
  output logic stack_push,
  output logic [15:0] stack_pc,
  output logic [3:0] stack_flags,
  output logic stack_irq_en,
  output logic [1:0] stack_banks,
  // flag update
  output logic flags_we,
  output logic [3:0] flags_out,
  // data memory, read data one cycle after dmem_re
  output logic dmem_re,
  output logic dmem_we,
  output logic [15:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata
);
  typedef enum {st_idle, st_run} st_e;
  typedef struct packed {
    st_e st;
    logic [2:0] cnt;
    logic load_pend;
    logic [4:0] load_reg;
    logic pc_load;
    logic [15:0] pc_tgt;
    logic push;
    logic [15:0] stk_pc;
    logic [3:0] stk_flags;
    logic stk_irq_en;
    logic [1:0] stk_banks;
    logic flags_we;
    logic [3:0] flags;
    logic dm_re;
    logic dm_we;
    logic [15:0] dm_addr;
    logic [7:0] dm_wdata;
  } state_s;
  state_s st_q;
  state_s st_d;

  exec_pkg::op_e op;
  logic accept;
  logic [4:0] rd_reg;
  logic [7:0] src_data;
  logic [7:0] acc_data;
  logic [1:0] ix_sel;
  logic [15:0] ix_data;
  logic ix_we;
  logic [15:0] ix_wdata;
  logic wr_en;
  logic [4:0] wr_reg;
  logic [7:0] wr_data;
  logic [7:0] imm_n;
  logic [7:0] imm_lim;
  logic [4:0] src_full;
  logic [4:0] src_lim;
  logic [1:0] idx_mode;
  logic cond_met;
  logic [7:0] or_res;

  // operand fields sit at fixed positions in every form except the index jump, which takes its pair select from bits 1:0
  assign op = exec_pkg::decode(instr_word);
  assign imm_n = instr_word[exec_pkg::IMM_HI:0];
  assign imm_lim = instr_word[exec_pkg::NI_HI:exec_pkg::NI_LO];
  assign src_full = instr_word[exec_pkg::SRC_HI:0];
  assign src_lim = {1'b0, instr_word[exec_pkg::RL_HI:0]};
  assign idx_mode = instr_word[exec_pkg::MODE_HI:exec_pkg::MODE_LO];
  assign or_res = src_data | imm_lim;

  // handshake: one instruction in flight, done in its last t-state
  assign accept = instr_valid && (st_q.st == st_idle);
  assign instr_ready = (st_q.st == st_idle);
  assign instr_done = (st_q.st == st_run) && (st_q.cnt == exec_pkg::CNT_LAST);

  // limited forms only reach R0-R15 through a four-bit field
  always_comb begin
    unique case (op)
      exec_pkg::op_ld_imm, exec_pkg::op_st_imm, exec_pkg::op_or_imm: begin
        rd_reg = src_lim;
      end
      default: begin
        rd_reg = src_full;
      end
    endcase
  end

  // immediate-relative always uses the fourth index register
  always_comb begin
    unique case (op)
      exec_pkg::op_ld_imm, exec_pkg::op_st_imm: ix_sel = exec_pkg::IDX3_SEL;
      exec_pkg::op_jump_idx: ix_sel = instr_word[exec_pkg::IRJ_HI:0];
      default: ix_sel = instr_word[exec_pkg::ISEL_HI:exec_pkg::ISEL_LO];
    endcase
  end

  assign cond_met = (src_data[instr_word[exec_pkg::ROT_HI:exec_pkg::ROT_LO]]
    == instr_word[exec_pkg::SBIT]);

  banked_regfile banked_regfile_i (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .bank_a_sel(bank_a_sel),
    .bank_b_sel(bank_b_sel),
    .rd_reg(rd_reg),
    .rd_data(src_data),
    .acc_data(acc_data),
    .ix_sel(ix_sel),
    .ix_data(ix_data),
    .ix_we(ix_we),
    .ix_wdata(ix_wdata),
    .wr_en(wr_en),
    .wr_reg(wr_reg),
    .wr_data(wr_data)
  );

  // rotate a copy right by b, clear top m bits and the lsb
  function automatic logic [7:0] table_disp(logic [7:0] v, logic [2:0] b, logic [2:0] m);
    logic [15:0] dbl;
    dbl = {v, v} >> b;
    return dbl[7:0] & (8'hFF >> m) & 8'hFE;
  endfunction

  // effective address of the general index mode
  function automatic logic [15:0] idx_addr(logic [15:0] ix, logic [1:0] md);
    return (md == exec_pkg::IDX_PRE_INC) ? ix + 16'h0001 : ix;
  endfunction

  // value written back to the index register
  function automatic logic [15:0] idx_next(logic [15:0] ix, logic [1:0] md);
    unique case (md)
      exec_pkg::IDX_POST_DEC: return ix - 16'h0001;
      exec_pkg::IDX_KEEP: return ix;
      exec_pkg::IDX_POST_INC, exec_pkg::IDX_PRE_INC: return ix + 16'h0001;
    endcase
  endfunction

  // next state; pulses clear themselves after one cycle
  always_comb begin
    st_d = st_q;
    st_d.pc_load = 1'b0;
    st_d.push = 1'b0;
    st_d.flags_we = 1'b0;
    st_d.dm_re = 1'b0;
    st_d.dm_we = 1'b0;
    wr_en = 1'b0;
    wr_reg = instr_word[exec_pkg::RD_HI:exec_pkg::RD_LO];
    wr_data = src_data;
    ix_we = 1'b0;
    ix_wdata = ix_data;
    if (st_q.st == st_run) begin
      st_d.cnt = st_q.cnt - 3'h1;
      if (st_q.cnt == exec_pkg::CNT_LAST) begin
        st_d.st = st_idle;
        if (st_q.load_pend) begin
          // memory answers one cycle after the read strobe
          wr_en = 1'b1;
          wr_reg = st_q.load_reg;
          wr_data = dmem_rdata;
          st_d.load_pend = 1'b0;
        end
      end
    end else if (accept) begin
      st_d.st = st_run;
      st_d.cnt = exec_pkg::T_SHORT - 3'h1;
      st_d.stk_pc = pc_in;
      st_d.stk_flags = flags_in;
      st_d.stk_irq_en = global_irq_enable;
      st_d.stk_banks = {bank_a_sel, bank_b_sel};
      st_d.dm_wdata = src_data;
      unique case (op)
        exec_pkg::op_rel_imm: begin
          st_d.cnt = exec_pkg::T_REL_IMM - 3'h1;
          st_d.pc_load = 1'b1;
          st_d.pc_tgt = pc_in + exec_pkg::sext8(imm_n);
        end
        exec_pkg::op_rel_reg: begin
          st_d.cnt = exec_pkg::T_REL_REG - 3'h1;
          st_d.pc_load = 1'b1;
          st_d.pc_tgt = pc_in + exec_pkg::sext8(src_data);
        end
        exec_pkg::op_table: begin
          st_d.cnt = exec_pkg::T_TABLE - 3'h1;
          st_d.pc_load = 1'b1;
          st_d.pc_tgt = pc_in + exec_pkg::sext8(table_disp(src_data,
            instr_word[exec_pkg::ROT_HI:exec_pkg::ROT_LO],
            instr_word[exec_pkg::MASK_HI:exec_pkg::MASK_LO]));
        end
        exec_pkg::op_call_abs: begin
          st_d.cnt = exec_pkg::T_LONG - 3'h1;
          st_d.push = 1'b1;
          st_d.pc_load = 1'b1;
          st_d.pc_tgt = instr_ext;
        end
        exec_pkg::op_call_cond: begin
          st_d.cnt = exec_pkg::T_LONG - 3'h1;
          st_d.push = cond_met;
          st_d.pc_load = cond_met;
          st_d.pc_tgt = instr_ext;
        end
        exec_pkg::op_jump_cond: begin
          st_d.cnt = exec_pkg::T_LONG - 3'h1;
          st_d.pc_load = cond_met;
          st_d.pc_tgt = instr_ext;
        end
        exec_pkg::op_jump_abs: begin
          st_d.cnt = exec_pkg::T_LONG - 3'h1;
          st_d.pc_load = 1'b1;
          st_d.pc_tgt = instr_ext;
        end
        exec_pkg::op_jump_idx: begin
          st_d.pc_load = 1'b1;
          st_d.pc_tgt = ix_data;
        end
        exec_pkg::op_ld_idx, exec_pkg::op_st_idx: begin
          st_d.cnt = exec_pkg::T_MEM - 3'h1;
          st_d.dm_addr = idx_addr(ix_data, idx_mode);
          ix_we = 1'b1;
          ix_wdata = idx_next(ix_data, idx_mode);
          st_d.dm_re = (op == exec_pkg::op_ld_idx);
          st_d.dm_we = (op == exec_pkg::op_st_idx);
          st_d.load_pend = (op == exec_pkg::op_ld_idx);
          st_d.load_reg = src_full;
        end
        exec_pkg::op_ld_rel, exec_pkg::op_st_rel: begin
          st_d.cnt = exec_pkg::T_MEM - 3'h1;
          st_d.dm_addr = ix_data + {8'h00, acc_data};
          st_d.dm_re = (op == exec_pkg::op_ld_rel);
          st_d.dm_we = (op == exec_pkg::op_st_rel);
          st_d.load_pend = (op == exec_pkg::op_ld_rel);
          st_d.load_reg = src_full;
        end
        exec_pkg::op_ld_imm, exec_pkg::op_st_imm: begin
          st_d.cnt = exec_pkg::T_MEM - 3'h1;
          st_d.dm_addr = ix_data + {8'h00, imm_lim};
          st_d.dm_re = (op == exec_pkg::op_ld_imm);
          st_d.dm_we = (op == exec_pkg::op_st_imm);
          st_d.load_pend = (op == exec_pkg::op_ld_imm);
          st_d.load_reg = src_lim;
        end
        exec_pkg::op_mov_rr: begin
          wr_en = 1'b1;
        end
        exec_pkg::op_or_imm: begin
          wr_en = 1'b1;
          wr_reg = src_lim;
          wr_data = or_res;
          st_d.flags_we = 1'b1;
          st_d.flags = flags_in;
          st_d.flags[exec_pkg::FLAG_N] = or_res[7];
          st_d.flags[exec_pkg::FLAG_Z] = (or_res == 8'h00);
        end
        exec_pkg::op_none: begin
          // unknown words retire as a two-cycle no-op
        end
      endcase
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{st: st_idle, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign pc_load = st_q.pc_load;
  assign pc_target = st_q.pc_tgt;
  assign stack_push = st_q.push;
  assign stack_pc = st_q.stk_pc;
  assign stack_flags = st_q.stk_flags;
  assign stack_irq_en = st_q.stk_irq_en;
  assign stack_banks = st_q.stk_banks;
  assign flags_we = st_q.flags_we;
  assign flags_out = st_q.flags;
  assign dmem_re = st_q.dm_re;
  assign dmem_we = st_q.dm_we;
  assign dmem_addr = st_q.dm_addr;
  assign dmem_wdata = st_q.dm_wdata;

  // checks: helper values computed apart from the datapath
  logic [15:0] chk_rel_tgt;
  logic [15:0] chk_idx3_addr;
  logic chk_ok;
  assign chk_rel_tgt = pc_in + {{8{imm_n[7]}}, imm_n};
  assign chk_idx3_addr = ix_data + {8'h00, imm_lim};
  assign chk_ok = accept;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_rel_target;
    chk_ok && op == exec_pkg::op_rel_imm |=> pc_load && pc_target == $past(chk_rel_tgt);
  endproperty
  a_rel_target: assert property (p_rel_target)
    else $error("relative jump target wrong");

  property p_rel_reg_time;
    chk_ok && op == exec_pkg::op_rel_reg |-> ##1 !instr_done [*2] ##1 instr_done;
  endproperty
  a_rel_reg_time: assert property (p_rel_reg_time)
    else $error("register relative jump not four cycles");

  property p_rel_imm_time;
    chk_ok && op == exec_pkg::op_rel_imm |-> ##1 !instr_done ##1 instr_done;
  endproperty
  a_rel_imm_time: assert property (p_rel_imm_time)
    else $error("immediate relative jump not three cycles");

  property p_table_even;
    chk_ok && op == exec_pkg::op_table |=> pc_load && (pc_target[0] == $past(pc_in[0]));
  endproperty
  a_table_even: assert property (p_table_even)
    else $error("table jump displacement not even");

  property p_call_push;
    chk_ok && op == exec_pkg::op_call_abs
      |=> stack_push && stack_pc == $past(pc_in) && pc_target == $past(instr_ext);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("long call did not push and load");

  property p_jump_no_push;
    chk_ok && op == exec_pkg::op_jump_cond |=> !stack_push [*4];
  endproperty
  a_jump_no_push: assert property (p_jump_no_push)
    else $error("conditional long jump pushed");

  property p_cond_fail;
    chk_ok && op == exec_pkg::op_call_cond && !cond_met |=> !pc_load && !stack_push;
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("failed condition changed flow");

  property p_idx3_addr;
    chk_ok && op == exec_pkg::op_ld_imm |=> dmem_re && dmem_addr == $past(chk_idx3_addr);
  endproperty
  a_idx3_addr: assert property (p_idx3_addr)
    else $error("immediate relative address wrong");

  property p_flags_only_or;
    flags_we |-> $past(chk_ok) && $past(op) == exec_pkg::op_or_imm
      && flags_out[1:0] == $past(flags_in[1:0]);
  endproperty
  a_flags_only_or: assert property (p_flags_only_or)
    else $error("flags written outside or-immediate");

  c_call_taken: cover property (chk_ok && op == exec_pkg::op_call_cond && cond_met);
  c_table: cover property (chk_ok && op == exec_pkg::op_table);
  c_load_inc: cover property (chk_ok && op == exec_pkg::op_ld_idx
    && idx_mode == exec_pkg::IDX_POST_INC);
endmodule

// ### dmem_model.sv
// data memory standing on the far side of the execution unit
// assumes read data is wanted only in the cycle after the read strobe
`timescale 1ns/1ps
module dmem_model (
  // clock
  input wire logic sys_clk,
  // access strobes
  input wire logic dmem_re,
  input wire logic dmem_we,
  input wire logic [15:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  // read data
  output logic [7:0] dmem_rdata
);
  logic [7:0] mem [0:65535];
  // data is good for one cycle only; it toggles otherwise so a late sample is caught
  always @(posedge sys_clk) begin
    if (dmem_we)
      mem[dmem_addr] <= dmem_wdata;
    if (dmem_re)
      dmem_rdata <= mem[dmem_addr];
    else
      dmem_rdata <= ~dmem_rdata;
  end
endmodule

// ### branch_call_move_exec_tb_top.sv
// self-checking bench for the branch, call and move unit
// assumes the data memory model and the design files are compiled first
`timescale 1ns/1ps
module branch_call_move_exec_tb_top;
  logic sys_clk, nrst, instr_valid, instr_ready, instr_done;
  logic [15:0] instr_word, instr_ext, pc_in, pc_target, stack_pc, dmem_addr;
  logic [3:0] flags_in, stack_flags, flags_out;
  logic global_irq_enable, bank_a_sel, bank_b_sel, pc_load, stack_push, stack_irq_en;
  logic flags_we, dmem_re, dmem_we;
  logic [1:0] stack_banks;
  logic [7:0] dmem_wdata, dmem_rdata;
  int n_errors, checks_done, t_cnt;
  // what the last instruction showed after it was taken
  logic saw_load, saw_push, saw_fwe, saw_we, s_irq;
  logic [15:0] tgt, s_pc, addr;
  logic [3:0] s_flags, f_out;
  logic [1:0] s_banks;
  logic [7:0] wdata;

  branch_call_move_exec branch_call_move_exec_i (.sys_clk(sys_clk), .nrst(nrst),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_ext(instr_ext),
    .pc_in(pc_in), .instr_ready(instr_ready), .instr_done(instr_done),
    .flags_in(flags_in), .global_irq_enable(global_irq_enable), .bank_a_sel(bank_a_sel),
    .bank_b_sel(bank_b_sel), .pc_load(pc_load), .pc_target(pc_target),
    .stack_push(stack_push), .stack_pc(stack_pc), .stack_flags(stack_flags),
    .stack_irq_en(stack_irq_en), .stack_banks(stack_banks), .flags_we(flags_we),
    .flags_out(flags_out), .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));
  dmem_model dmem_model_i (.sys_clk(sys_clk), .dmem_re(dmem_re), .dmem_we(dmem_we),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pulses all land in one cycle, so record whatever shows up
  task automatic sample;
    if (pc_load === 1'b1) begin
      saw_load = 1'b1;
      tgt = pc_target;
    end
    if (stack_push === 1'b1) begin
      saw_push = 1'b1;
      {s_pc, s_flags, s_irq, s_banks} = {stack_pc, stack_flags, stack_irq_en, stack_banks};
    end
    if (flags_we === 1'b1) begin
      saw_fwe = 1'b1;
      f_out = flags_out;
    end
    if (dmem_we === 1'b1) begin
      saw_we = 1'b1;
      {addr, wdata} = {dmem_addr, dmem_wdata};
    end
  endtask

  // valid stays up after done; a word offered while busy is simply not taken
  task automatic issue(input logic [15:0] w, input logic [15:0] x);
    int k;
    {instr_word, instr_ext, instr_valid} = {w, x, 1'b1};
    {saw_load, saw_push, saw_fwe, saw_we} = 4'h0;
    {tgt, addr, wdata} = 'x;
    k = 0;
    while (instr_ready !== 1'b1 && k < 10) begin
      k++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    t_cnt = 1;
    @(negedge sys_clk);
    while (instr_done !== 1'b1 && t_cnt < 10) begin
      sample;
      t_cnt++;
      @(negedge sys_clk);
    end
    sample;
    t_cnt++;
  endtask

  // registers are set by a load through the first index pair, left at zero
  task automatic set_reg(input logic [4:0] r, input logic [7:0] v);
    dmem_model_i.mem[0] = v;
    issue(16'hE080 | {11'h000, r}, 16'h0000);
  endtask

  task automatic get_reg(input logic [4:0] r, output logic [7:0] v);
    issue(16'hE280 | {11'h000, r}, 16'h0000);
    v = wdata;
  endtask

  task automatic t_rel;
    pc_in = 16'h1000;
    issue(16'hCB80, 16'h0000);
    chk("rel imm target", 16'h0F80, tgt);
    chk("rel imm cycles", 16'h0003, 16'(t_cnt));
    issue(16'hCB7F, 16'h0000);
    chk("rel imm fwd", 16'h107F, tgt);
    set_reg(5'h14, 8'h90);
    issue(16'hCD94, 16'h0000);
    chk("rel reg target", 16'h0F90, tgt);
    chk("rel reg cycles", 16'h0004, 16'(t_cnt));
  endtask

  task automatic t_table;
    logic [7:0] v, r, d;
    set_reg(5'h19, 8'hB5);
    pc_in = 16'h2000;
    for (int b = 0; b < 8; b++) begin
      for (int m = 0; m < 8; m++) begin
        v = 8'hB5;
        r = (v >> b) | (v << (8 - b));
        d = r & (8'hFF >> m) & 8'hFE;
        issue(16'h8019 | 16'(m << 10) | 16'(b << 5), 16'h0000);
        chk("table target", pc_in + {{8{d[7]}}, d}, tgt);
        chk("table cycles", 16'h0004, 16'(t_cnt));
      end
    end
    get_reg(5'h19, v);
    chk("table source", 16'h00B5, {8'h00, v});
  endtask

  task automatic t_cond;
    logic met;
    set_reg(5'h15, 8'hA6);
    pc_in = 16'h3000;
    for (int i = 0; i < 32; i++) begin
      met = ((8'hA6 >> (i % 8)) & 1) == i[3];
      issue((i[4] ? 16'hC615 : 16'hC415) | 16'((i & 8) << 5) | 16'((i % 8) << 5), 16'hFEDC);
      chk("cond push", {15'h0000, met & ~i[4]}, {15'h0000, saw_push});
      chk("cond load", {15'h0000, met}, {15'h0000, saw_load});
      chk("cond cycles", 16'h0004, 16'(t_cnt));
      if (met)
        chk("cond target", 16'hFEDC, tgt);
    end
  endtask

  task automatic t_call;
    {flags_in, global_irq_enable, bank_a_sel, pc_in} = {4'hA, 1'b1, 1'b1, 16'h4321};
    issue(16'hCE00, 16'hFFFF);
    chk("call target", 16'hFFFF, tgt);
    chk("call push", 16'h0001, {15'h0000, saw_push});
    chk("call pc", 16'h4321, s_pc);
    chk("call ctx", 16'h0056, {9'h000, s_flags, s_irq, s_banks});
    {flags_in, bank_a_sel} = {4'h0, 1'b0};
    issue(16'hCF00, 16'h0000);
    chk("jump target", 16'h0000, tgt);
    chk("jump push", 16'h0000, {15'h0000, saw_push});
    set_reg(5'h0E, 8'h34);
    set_reg(5'h0F, 8'h12);
    issue(16'hCD01, 16'h0000);
    chk("jump index", 16'h1234, tgt);
    chk("jump index cycles", 16'h0002, 16'(t_cnt));
  endtask

  task automatic t_mem;
    logic [15:0] ea [4] = '{16'h0200, 16'h01FF, 16'h01FF, 16'h0201};
    logic [7:0] v;
    set_reg(5'h10, 8'h00);
    set_reg(5'h11, 8'h02);
    for (int md = 0; md < 4; md++) begin
      issue(16'hE254 | 16'(md << 7), 16'h0000);
      chk("index addr", ea[md], addr);
      chk("index data", 16'h0090, {8'h00, wdata});
      chk("index flags", 16'h0000, {15'h0000, saw_fwe});
    end
    set_reg(5'h00, 8'hF0);
    issue(16'hE654, 16'h0000);
    chk("acc rel addr", 16'h02F1, addr);
    issue(16'hE45E, 16'h0000);
    get_reg(5'h1E, v);
    chk("acc rel load", 16'h0090, {8'h00, v});
    bank_a_sel = 1'b1;
    get_reg(5'h00, v);
    chk("alt acc", 16'h0000, {8'h00, v});
    bank_a_sel = 1'b0;
    get_reg(5'h00, v);
    chk("main acc", 16'h00F0, {8'h00, v});
  endtask

  task automatic t_imm;
    logic [7:0] v;
    flags_in = 4'h3;
    issue(16'h5815, 16'h0000);
    chk("or flags neg", 16'h000B, {12'h000, f_out});
    chk("or cycles", 16'h0002, 16'(t_cnt));
    issue(16'h5006, 16'h0000);
    chk("or flags zero", 16'h0007, {12'h000, f_out});
    issue(16'h7FF5, 16'h0000);
    chk("imm rel addr", 16'h00FF, addr);
    chk("imm rel data", 16'h0081, {8'h00, wdata});
    issue(16'h6FF7, 16'h0000);
    issue(16'hF7E7, 16'h0000);
    chk("move flags", 16'h0000, {15'h0000, saw_fwe});
    get_reg(5'h1F, v);
    chk("move data", 16'h0081, {8'h00, v});
    issue(16'h0000, 16'h0000);
    chk("unknown cycles", 16'h0002, 16'(t_cnt));
    chk("unknown effects", 16'h0000, {12'h000, saw_load, saw_push, saw_we, saw_fwe});
  endtask

  // clock at 10 MHz
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // main sequence, inputs change on the falling edge
  initial begin
    {nrst, instr_valid, instr_word, instr_ext, pc_in} = '0;
    {flags_in, global_irq_enable, bank_a_sel, bank_b_sel} = '0;
    repeat (16) @(negedge sys_clk);
    chk("reset outputs", 16'h0010,
      {10'h000, pc_load, instr_ready, stack_push, dmem_we, dmem_re, flags_we});
    nrst = 1'b1;
    @(negedge sys_clk);
    t_rel;
    t_table;
    t_cond;
    t_call;
    t_mem;
    t_imm;
    instr_valid = 1'b0;
    results;
  end

  // a hang ends the run after far more cycles than the sequence needs
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    results;
  end
endmodule
